// file: hdl/psfa_consts.svh
`ifndef PSFA_CONSTS_SVH
`define PSFA_CONSTS_SVH

// ****************************************
// Geometry of the peripheral setting file
// ****************************************
`define PSFA_CTRL_WORDS 64
`define PSFA_BANK_COUNT 4
`define PSFA_DMEM_WORDS 512
`define PSFA_CTRL_LAST 7'h3f
`define PSFA_ALIAS_FIRST 7'h40

// ****************************************
// System register offsets
// ****************************************
`define PSFA_SYS_AR3 7'h74
`define PSFA_SYS_AR2 7'h75
`define PSFA_SYS_AR1 7'h76
`define PSFA_SYS_AR0 7'h77
`define PSFA_SYS_WINDOW 7'h78
`define PSFA_SYS_BANK 7'h79
`define PSFA_SYS_IXH 7'h7a
`define PSFA_SYS_IXM 7'h7b
`define PSFA_SYS_IXL 7'h7c

// ****************************************
// Valid bit masks and fixed values
// ****************************************
`define PSFA_BANK_MASK 4'h3
`define PSFA_AR_MASK 16'h3fff
`define PSFA_IX_MASK 12'h1ff
`define PSFA_RESET_NIB 4'h0
`define PSFA_UNDEF_VAL 4'h0
`define PSFA_SYS_DEFAULT 4'h0

// ****************************************
// Control register attributes
// ****************************************
`define PSFA_UNUSED_FIRST 7'h20
`define PSFA_UNUSED_LAST 7'h2f
`define PSFA_WO_ADDR 7'h3a
`define PSFA_RC_ADDR 7'h3b
`define PSFA_RO_FIRST 7'h3c
`define PSFA_MASK_ADDR 7'h01
`define PSFA_MASK_VAL 4'h7

`endif

// file: hdl/psfa_pkg.sv
package psfa_pkg;
	typedef enum logic [2:0] {
		PSFA_ATTR_RW = 3'h0,
		PSFA_ATTR_RO = 3'h1,
		PSFA_ATTR_WO = 3'h2,
		PSFA_ATTR_RC = 3'h3,
		PSFA_ATTR_NONE = 3'h4
	} psfa_attr_type;
	typedef logic [3:0] psfa_nib_type;
	typedef logic [6:0] psfa_addr_type;
endpackage : psfa_pkg

// file: hdl/psfa_file.sv
// Overview of operation
// [RULE1] The file holds 128 four-bit words addressed in nibbles like data memory.
// [RULE2] A file address is a row 0 to 7 joined to a column 0 to 15.
// [RULE3] Addresses 00 to 3F are the peripheral control registers, apart from data memory.
// [RULE4] Addresses 40 to 7F have no storage of their own and are data memory cells 40 to 7F.
// [RULE5] The upper range follows whichever data memory bank is selected at the time.
// [RULE6] The window register at system address 78 is the only data path into and out of the file.
// [RULE7] A file read instruction copies the addressed nibble into the window register.
// [RULE8] A file write instruction copies the window register into the addressed location.
// [RULE9] A transfer into the control area moves data only between that register and the window.
// [RULE10] A transfer at 40 to 7F works on that data memory address in the selected bank.
// [RULE11] Ordinary data memory accesses reach the aliased range with the same effect.
// [RULE12] System register bits fixed at zero ignore writes and always read zero.
// [RULE13] Incrementing the address or index pointer with all valid bits one clears them.
// [RULE14] Writes to a read-only or read-and-clear control register change nothing.
// [RULE15] Reading a write-only control register returns the undefined value, not its contents.
// [RULE16] Every transfer completes in one cycle, visible to the next instruction.
`timescale 1ns/10ps
`include "psfa_consts.svh"

module psfa_file
	import psfa_pkg::*;
(
	input wire logic ref_clk, // 200 MHz core clock
	input wire logic reset, // Synchronous, active high
	input wire logic peekStb, // file_read_instr this cycle
	input wire logic pokeStb, // file_write_instr this cycle
	input wire logic [6:0] fileAddr, // File address of the transfer
	input wire logic dmRdEn, // Ordinary data memory read
	input wire logic dmWrEn, // Ordinary data memory write
	input wire logic [6:0] dmAddr, // Data memory address in bank
	input wire logic [3:0] dmWrData, // Data memory write nibble
	output logic [3:0] dmRdData, // Data memory read nibble
	input wire logic sysRdEn, // System register read
	input wire logic sysWrEn, // System register write
	input wire logic [6:0] sysAddr, // System register address
	input wire logic [3:0] sysWrData, // System register write nibble
	output logic [3:0] sysRdData, // System register read nibble
	input wire logic arIncStb, // Increment address_pointer
	input wire logic ixIncStb, // Increment index_pointer
	input wire logic [15:0] statusIn, // Read-only control nibbles
	input wire logic [3:0] eventIn, // Events into read-and-clear nibble
	output logic [255:0] ctrlRegs, // Control register contents
	output logic [1:0] bankSel, // Selected data memory bank
	output logic [13:0] addrPtr, // address_pointer
	output logic [8:0] indexPtr // index_pointer
);

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic psfa_attr_type attrOf(input logic [6:0] a);
		psfa_attr_type t;
		t = PSFA_ATTR_RW;
		if (a >= `PSFA_UNUSED_FIRST && a <= `PSFA_UNUSED_LAST) begin
			t = PSFA_ATTR_NONE;
		end else if (a == `PSFA_WO_ADDR) begin
			t = PSFA_ATTR_WO;
		end else if (a == `PSFA_RC_ADDR) begin
			t = PSFA_ATTR_RC;
		end else if (a >= `PSFA_RO_FIRST && a <= `PSFA_CTRL_LAST) begin
			t = PSFA_ATTR_RO;
		end
		return t;
	endfunction : attrOf

	// Bits that exist in a control nibble; the rest stay zero
	function automatic logic [3:0] ctrlMask(input logic [6:0] a);
		return (a == `PSFA_MASK_ADDR) ? `PSFA_MASK_VAL : 4'hf;
	endfunction : ctrlMask

	function automatic logic [3:0] nibOf16(input logic [15:0] v, input logic [1:0] i);
		return v[{i, 2'b00} +: 4];
	endfunction : nibOf16

	function automatic logic [15:0] putNib16(input logic [15:0] v, input logic [1:0] i,
		input logic [3:0] n);
		logic [15:0] r;
		r = v;
		r[{i, 2'b00} +: 4] = n;
		return r;
	endfunction : putNib16

	// ****************************************
	// Storage
	// ****************************************
	logic [3:0] ctrl_q [0:`PSFA_CTRL_WORDS-1];
	logic [3:0] dmem_q [0:`PSFA_DMEM_WORDS-1];
	logic [3:0] window_q, window_d;
	logic [3:0] rcFlags_q, rcFlags_d;
	logic [3:0] bank_q, bank_d;
	logic [15:0] ar_q, ar_d;
	logic [11:0] ix_q, ix_d;
	logic [3:0] dmRd_q;
	logic [3:0] sysRd_q, sysRd_d;

	// ****************************************
	// Decode
	// ****************************************
	wire ctrlHit = (fileAddr <= `PSFA_CTRL_LAST); // [RULE3]
	wire [5:0] ctrlIdx = fileAddr[5:0];
	// Upper file range is the selected bank's data memory; no storage of its own
	wire [8:0] rfDmIdx = {bank_q[1:0], fileAddr}; // [RULE4] [RULE5] [RULE10]
	wire [8:0] dmIdx = {bank_q[1:0], dmAddr}; // [RULE11]
	wire psfa_attr_type fileAttr = attrOf(fileAddr);
	wire [3:0] fileMask = ctrlMask(fileAddr);
	wire [3:0] roNib = statusIn[{fileAddr[1:0], 2'b00} +: 4];
	wire ctrlWritable = (fileAttr == PSFA_ATTR_RW) || (fileAttr == PSFA_ATTR_WO); // [RULE14]
	wire pokeCtrl = pokeStb && ctrlHit && ctrlWritable; // [RULE9]
	wire pokeDm = pokeStb && !ctrlHit; // [RULE10]
	wire rcClear = peekStb && (fileAddr == `PSFA_RC_ADDR);
	wire [3:0] ctrlRdVal = (fileAttr == PSFA_ATTR_RW) ? (ctrl_q[ctrlIdx] & fileMask) :
		(fileAttr == PSFA_ATTR_RO) ? roNib :
		(fileAttr == PSFA_ATTR_RC) ? rcFlags_q :
		`PSFA_UNDEF_VAL; // [RULE15]
	wire [3:0] fileRdVal = ctrlHit ? ctrlRdVal : dmem_q[rfDmIdx]; // [RULE9] [RULE10]
	wire sysWrWin = sysWrEn && (sysAddr == `PSFA_SYS_WINDOW);
	wire sysWrBank = sysWrEn && (sysAddr == `PSFA_SYS_BANK);
	wire sysWrAr = sysWrEn && (sysAddr >= `PSFA_SYS_AR3) && (sysAddr <= `PSFA_SYS_AR0);
	wire sysWrIx = sysWrEn && (sysAddr >= `PSFA_SYS_IXH) && (sysAddr <= `PSFA_SYS_IXL);
	wire [1:0] arNibIdx = 2'h3 - sysAddr[1:0] + 2'h0;
	wire [1:0] ixNibIdx = 2'(`PSFA_SYS_IXL - sysAddr);

	// ****************************************
	// Next values
	// ****************************************
	// A file read overrides a simultaneous system write to the window
	assign window_d = peekStb ? fileRdVal : (sysWrWin ? sysWrData : window_q); // [RULE6] [RULE7]
	// A new event beats a clear in the same cycle
	assign rcFlags_d = (rcClear ? 4'h0 : rcFlags_q) | eventIn;
	assign bank_d = sysWrBank ? (sysWrData & `PSFA_BANK_MASK) : bank_q; // [RULE12]
	// Increment wins over a write in the same cycle; the mask wraps all-ones to zero
	assign ar_d = arIncStb ? ((ar_q + 16'h1) & `PSFA_AR_MASK) : // [RULE13]
		(sysWrAr ? (putNib16(ar_q, arNibIdx, sysWrData) & `PSFA_AR_MASK) : ar_q); // [RULE12]
	assign ix_d = ixIncStb ? ((ix_q + 12'h1) & `PSFA_IX_MASK) : // [RULE13]
		(sysWrIx ? (12'(putNib16({4'h0, ix_q}, ixNibIdx, sysWrData)) & `PSFA_IX_MASK) :
		ix_q); // [RULE12]
	assign sysRd_d = (sysAddr == `PSFA_SYS_WINDOW) ? window_q :
		(sysAddr == `PSFA_SYS_BANK) ? bank_q :
		(sysAddr >= `PSFA_SYS_AR3 && sysAddr <= `PSFA_SYS_AR0) ? nibOf16(ar_q, arNibIdx) :
		(sysAddr >= `PSFA_SYS_IXH && sysAddr <= `PSFA_SYS_IXL) ?
		nibOf16({4'h0, ix_q}, ixNibIdx) : `PSFA_SYS_DEFAULT;

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			window_q <= `PSFA_RESET_NIB;
			rcFlags_q <= `PSFA_RESET_NIB;
			bank_q <= `PSFA_RESET_NIB;
			ar_q <= 16'h0000;
			ix_q <= 12'h000;
			dmRd_q <= `PSFA_RESET_NIB;
			sysRd_q <= `PSFA_RESET_NIB;
		end else begin
			window_q <= window_d; // [RULE16]
			rcFlags_q <= rcFlags_d;
			bank_q <= bank_d;
			ar_q <= ar_d;
			ix_q <= ix_d;
			if (dmRdEn) begin
				dmRd_q <= dmem_q[dmIdx]; // [RULE11]
			end
			if (sysRdEn) begin
				sysRd_q <= sysRd_d;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < `PSFA_CTRL_WORDS; i++) begin
				ctrl_q[i] <= `PSFA_RESET_NIB;
			end
		end else if (pokeCtrl) begin
			ctrl_q[ctrlIdx] <= window_q & fileMask; // [RULE8] [RULE12]
		end
	end

	// Data memory is not cleared by reset; a file write wins over an ordinary write
	always_ff @(posedge ref_clk) begin
		if (pokeDm) begin
			dmem_q[rfDmIdx] <= window_q; // [RULE8] [RULE10]
		end else if (dmWrEn) begin
			dmem_q[dmIdx] <= dmWrData; // [RULE11]
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `PSFA_CTRL_WORDS; g++) begin : gCtrlOut
			assign ctrlRegs[g*4 +: 4] = ctrl_q[g]; // [RULE1] [RULE2]
		end
	endgenerate
	assign dmRdData = dmRd_q;
	assign sysRdData = sysRd_q;
	assign bankSel = bank_q[1:0];
	assign addrPtr = ar_q[13:0];
	assign indexPtr = ix_q[8:0];

	// ****************************************
	// Assertion helpers
	// ****************************************
	// Last bank value written, kept apart from the bank register it is checked against
	logic [1:0] bankWr_q;
	always_ff @(posedge ref_clk) begin
		if (sysWrBank) begin
			bankWr_q <= sysWrData[1:0];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_file_read_instr_window_load: assert property (peekStb |=> window_q == $past(fileRdVal)) // [RULE7]
		else $error("window did not take the file nibble");
	a_file_write_instr_ctrl_store: assert property (pokeCtrl |=> // [RULE8]
		ctrl_q[$past(ctrlIdx)] == ($past(window_q) & $past(fileMask)))
		else $error("control register did not take the window");
	a_file_write_instr_alias_store: assert property (pokeDm |=> // [RULE10]
		dmem_q[$past(rfDmIdx)] == $past(window_q))
		else $error("aliased data memory did not take the window");
	a_ctrl_dm_untouched: assert property (pokeStb && ctrlHit && !dmWrEn |=> // [RULE9]
		dmem_q[$past(rfDmIdx)] == $past(dmem_q[rfDmIdx]))
		else $error("control transfer touched data memory");
	a_dm_write_alias: assert property (dmWrEn && !pokeStb |=> // [RULE11]
		dmem_q[$past(dmIdx)] == $past(dmWrData))
		else $error("ordinary write missed data memory");
	a_rc_write_kept: assert property (pokeStb && fileAddr == `PSFA_RC_ADDR && !peekStb |=> // [RULE14]
		(rcFlags_q & $past(rcFlags_q)) == $past(rcFlags_q))
		else $error("write disturbed a read-and-clear register");
	a_wo_read_undef: assert property (peekStb && fileAttr == PSFA_ATTR_WO |=> // [RULE15]
		window_q == `PSFA_UNDEF_VAL)
		else $error("write-only register returned its contents");
	a_ar_wrap_zero: assert property (arIncStb && ar_q == `PSFA_AR_MASK |=> ar_q == 16'h0000) // [RULE13]
		else $error("address pointer did not wrap to zero");
	a_ix_wrap_zero: assert property (ixIncStb && ix_q == `PSFA_IX_MASK |=> ix_q == 12'h000) // [RULE13]
		else $error("index pointer did not wrap to zero");
	a_bank_zero_bits: assert property (sysRdEn && sysAddr == `PSFA_SYS_BANK |=> // [RULE12]
		sysRdData[3:2] == 2'b00)
		else $error("fixed-zero bank bits read as one");
	a_bank_follow: assert property (sysWrBank ##2 (peekStb && !ctrlHit) |=> // [RULE5]
		window_q == $past(dmem_q[{bankWr_q, fileAddr}]))
		else $error("alias did not follow the new bank");

	// Window traffic, ordinary data memory reads and control area attributes
	a_window_hold: assert property (!peekStb && !sysWrWin |=> // [RULE6]
		window_q == $past(window_q))
		else $error("window changed without a transfer");
	a_sys_win_write: assert property (sysWrWin && !peekStb |=> // [RULE6]
		window_q == $past(sysWrData))
		else $error("window did not take the system write");
	a_win_read_data: assert property (sysRdEn && sysAddr == `PSFA_SYS_WINDOW |=> // [RULE6]
		sysRdData == $past(window_q))
		else $error("window read returned a wrong nibble");
	a_dm_read_data: assert property (dmRdEn |=> // [RULE11]
		dmRdData == $past(dmem_q[dmIdx]))
		else $error("ordinary read returned a wrong nibble");
	a_ro_file_write_instr_kept: assert property (pokeStb && ctrlHit && !ctrlWritable |=> // [RULE14]
		ctrl_q[$past(ctrlIdx)] == $past(ctrl_q[ctrlIdx]))
		else $error("write changed a protected control register");
	a_ro_file_read_instr_status: assert property (peekStb && fileAttr == PSFA_ATTR_RO |=> // [RULE7]
		window_q == $past(statusIn[{fileAddr[1:0], 2'b00} +: 4]))
		else $error("read-only register returned a wrong nibble");
	a_unused_read_undef: assert property (peekStb && fileAttr == PSFA_ATTR_NONE |=> // [RULE15]
		window_q == `PSFA_UNDEF_VAL)
		else $error("unused register returned stored contents");
	a_file_write_instr_visible: assert property (pokeCtrl |=> // [RULE16]
		ctrlRegs[{$past(ctrlIdx), 2'b00} +: 4] == ($past(window_q) & $past(fileMask)))
		else $error("control write not visible on the next cycle");
	a_rc_file_read_instr_clear: assert property (rcClear && eventIn == 4'h0 |=> // [RULE14]
		rcFlags_q == 4'h0)
		else $error("read-and-clear register not cleared by a read");

	// Fixed-zero bits and pointer steps
	a_bank_fixed_zero: assert property (bank_q[3:2] == 2'b00) // [RULE12]
		else $error("fixed-zero bank bits set");
	a_ar_fixed_zero: assert property (ar_q[15:14] == 2'b00) // [RULE12]
		else $error("fixed-zero address pointer bits set");
	a_ix_fixed_zero: assert property (ix_q[11:9] == 3'b000) // [RULE12]
		else $error("fixed-zero index pointer bits set");
	a_ar_step_one: assert property (arIncStb && ar_q != `PSFA_AR_MASK |=> // [RULE13]
		ar_q == $past(ar_q) + 16'h1)
		else $error("address pointer did not step by one");
	a_ix_step_one: assert property (ixIncStb && ix_q != `PSFA_IX_MASK |=> // [RULE13]
		ix_q == $past(ix_q) + 12'h1)
		else $error("index pointer did not step by one");

	// Main scenarios
	c_file_read_instr_ctrl: cover property (peekStb && ctrlHit ##1 sysRdEn && sysAddr == `PSFA_SYS_WINDOW);
	c_bank_follow: cover property (sysWrBank ##2 (peekStb && !ctrlHit));
	c_file_write_instr_alias: cover property (pokeDm ##1 dmRdEn);
	c_ar_wrap: cover property (arIncStb && ar_q == `PSFA_AR_MASK);
	c_rc_clear: cover property (rcClear && rcFlags_q != 4'h0);

endmodule : psfa_file

// file: tb/psfa_cpu_model.sv
`timescale 1ns/10ps

// ****************************************
// CPU core side of the peripheral setting file
// ****************************************
module psfa_cpu_model (
	input wire logic ref_clk, // Core clock
	output logic peekStb, // File read
	output logic pokeStb, // File write
	output logic [6:0] fileAddr, // File address
	output logic dmRdEn, // Memory read
	output logic dmWrEn, // Memory write
	output logic [6:0] dmAddr, // Memory address
	output logic [3:0] dmWrData, // Memory write nibble
	input wire logic [3:0] dmRdData, // Memory read nibble
	output logic sysRdEn, // System read
	output logic sysWrEn, // System write
	output logic [6:0] sysAddr, // System address
	output logic [3:0] sysWrData, // System write nibble
	input wire logic [3:0] sysRdData, // System read nibble
	output logic arIncStb, // Pointer increment
	output logic ixIncStb // Index increment
);
	initial begin
		{peekStb, pokeStb, dmRdEn, dmWrEn, sysRdEn, sysWrEn, arIncStb, ixIncStb} = 8'h00;
		{fileAddr, dmAddr, sysAddr} = 21'h0;
		{dmWrData, sysWrData} = 8'h00;
	end

	// Every request is launched 1 ns after an edge and taken at the next one
	// Each task then idles one edge so no strobe is lowered and raised at one instant
	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask : step

	// Released data lines flip so stale values never look valid
	task automatic sysWr(input logic [6:0] a, input logic [3:0] d);
		sysAddr = a;
		sysWrData = d;
		sysWrEn = 1'b1;
		step();
		sysWrEn = 1'b0;
		sysWrData = ~d;
		step();
	endtask : sysWr

	task automatic sysRd(input logic [6:0] a, output logic [3:0] d);
		sysAddr = a;
		sysRdEn = 1'b1;
		step();
		d = sysRdData;
		sysRdEn = 1'b0;
		step();
	endtask : sysRd

	task automatic dmWr(input logic [6:0] a, input logic [3:0] d);
		dmAddr = a;
		dmWrData = d;
		dmWrEn = 1'b1;
		step();
		dmWrEn = 1'b0;
		dmWrData = ~d;
		step();
	endtask : dmWr

	task automatic dmRd(input logic [6:0] a, output logic [3:0] d);
		dmAddr = a;
		dmRdEn = 1'b1;
		step();
		d = dmRdData;
		dmRdEn = 1'b0;
		step();
	endtask : dmRd

	task automatic xfer(input logic wr, input logic [6:0] a);
		fileAddr = a;
		pokeStb = wr;
		peekStb = !wr;
		step();
		pokeStb = 1'b0;
		peekStb = 1'b0;
		fileAddr = ~a;
		step();
	endtask : xfer

	task automatic inc(input logic ix);
		ixIncStb = ix;
		arIncStb = !ix;
		step();
		ixIncStb = 1'b0;
		arIncStb = 1'b0;
		step();
	endtask : inc
endmodule : psfa_cpu_model

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] statusIn = 16'h4321;
	logic [3:0] eventIn = 4'h0;
	logic peekStb, pokeStb, dmRdEn, dmWrEn, sysRdEn, sysWrEn, arIncStb, ixIncStb;
	logic [6:0] fileAddr, dmAddr, sysAddr;
	logic [3:0] dmWrData, dmRdData, sysWrData, sysRdData, v;
	logic [255:0] ctrlRegs;
	logic [1:0] bankSel;
	logic [13:0] addrPtr;
	logic [8:0] indexPtr;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #2.5 ref_clk = ~ref_clk;

	psfa_file uut (.ref_clk(ref_clk), .reset(reset), .peekStb(peekStb), .pokeStb(pokeStb),
		.fileAddr(fileAddr), .dmRdEn(dmRdEn), .dmWrEn(dmWrEn), .dmAddr(dmAddr),
		.dmWrData(dmWrData), .dmRdData(dmRdData), .sysRdEn(sysRdEn), .sysWrEn(sysWrEn),
		.sysAddr(sysAddr), .sysWrData(sysWrData), .sysRdData(sysRdData), .arIncStb(arIncStb),
		.ixIncStb(ixIncStb), .statusIn(statusIn), .eventIn(eventIn), .ctrlRegs(ctrlRegs),
		.bankSel(bankSel), .addrPtr(addrPtr), .indexPtr(indexPtr));

	psfa_cpu_model cpu (.ref_clk(ref_clk), .peekStb(peekStb), .pokeStb(pokeStb),
		.fileAddr(fileAddr), .dmRdEn(dmRdEn), .dmWrEn(dmWrEn), .dmAddr(dmAddr),
		.dmWrData(dmWrData), .dmRdData(dmRdData), .sysRdEn(sysRdEn), .sysWrEn(sysWrEn),
		.sysAddr(sysAddr), .sysWrData(sysWrData), .sysRdData(sysRdData),
		.arIncStb(arIncStb), .ixIncStb(ixIncStb));

	task automatic stop_test;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdChk(input logic [6:0] a, input logic [3:0] exp);
		logic [3:0] d;
		cpu.sysRd(a, d);
		chk(16'(d), 16'(exp));
	endtask : rdChk

	// Window is only reachable through the system port
	task automatic peekChk(input logic [6:0] a, input logic [3:0] exp);
		cpu.xfer(1'b0, a);
		rdChk(7'h78, exp);
	endtask : peekChk

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		cpu.step();
		rdChk(7'h78, 4'h0);
		// Known memory under the control addresses, so control pokes can be seen to spare it
		for (int i = 0; i < 64; i++) cpu.dmWr(i[6:0], 4'h0);
		cpu.dmWr(7'h05, 4'ha);
		cpu.sysWr(7'h78, 4'h5);
		cpu.xfer(1'b1, 7'h05);
		chk(16'(ctrlRegs[23:20]), 16'h0005);
		cpu.dmRd(7'h05, v);
		chk(16'(v), 16'h000a);
		peekChk(7'h05, 4'h5);
		for (int b = 0; b < 4; b++) begin
			cpu.sysWr(7'h79, b[3:0]);
			cpu.sysWr(7'h78, 4'h8 | b[3:0]);
			cpu.xfer(1'b1, 7'h45);
			cpu.dmWr(7'h46, 4'hc ^ b[3:0]);
		end
		for (int b = 0; b < 4; b++) begin
			cpu.sysWr(7'h79, b[3:0]);
			peekChk(7'h46, 4'hc ^ b[3:0]);
			cpu.dmRd(7'h45, v);
			chk(16'(v), 16'(4'h8 | b[3:0]));
		end
		cpu.sysWr(7'h79, 4'hf);
		chk(16'(bankSel), 16'h0003);
		rdChk(7'h79, 4'h3);
		cpu.sysWr(7'h79, 4'h0);
		cpu.sysWr(7'h78, 4'hf);
		cpu.xfer(1'b1, 7'h01);
		peekChk(7'h01, 4'h7);
		for (int i = 0; i < 4; i++) cpu.sysWr(7'h74 + i[6:0], 4'hf);
		rdChk(7'h74, 4'h3);
		cpu.inc(1'b0);
		chk(16'(addrPtr), 16'h0000);
		cpu.inc(1'b0);
		chk(16'(addrPtr), 16'h0001);
		for (int i = 0; i < 3; i++) cpu.sysWr(7'h7a + i[6:0], 4'hf);
		rdChk(7'h7a, 4'h1);
		cpu.inc(1'b1);
		chk(16'(indexPtr), 16'h0000);
		cpu.inc(1'b1);
		chk(16'(indexPtr), 16'h0001);
		cpu.sysWr(7'h78, 4'hf);
		cpu.xfer(1'b1, 7'h3c);
		chk(16'(ctrlRegs[243:240]), 16'h0000);
		peekChk(7'h3c, 4'h1);
		eventIn = 4'h5;
		cpu.step();
		eventIn = 4'h0;
		cpu.sysWr(7'h78, 4'hf);
		cpu.xfer(1'b1, 7'h3b);
		peekChk(7'h3b, 4'h5);
		peekChk(7'h3b, 4'h0);
		cpu.sysWr(7'h78, 4'h9);
		cpu.xfer(1'b1, 7'h3a);
		chk(16'(ctrlRegs[235:232]), 16'h0009);
		peekChk(7'h3a, 4'h0);
		cpu.sysWr(7'h78, 4'h6);
		cpu.xfer(1'b1, 7'h20);
		chk(16'(ctrlRegs[131:128]), 16'h0000);
		peekChk(7'h20, 4'h0);
		stop_test();
	end
endmodule : testbench
